// >>> omc_ext_bus_model.sv
// external memory bus sink: logs every bus phase the block drives
`timescale 1ns/1ps
module omc_ext_bus_model (
    input wire logic               clk,
    input wire omc_pkg::omc_pins_t port_pins
);
    logic [15:0] log [$];

    // write-only memory: it never answers, it only records {port a, port b}
    always @(posedge clk) begin
        if (port_pins.pa_oe === 1'b1) begin
            log.push_back({port_pins.pa_out, port_pins.pb_out});
        end
    end
endmodule

// >>> omc_params.svh
// constants for the operating-mode control block
`ifndef OMC_PARAMS_SVH
`define OMC_PARAMS_SVH

`define OMC_APB_AW      12
`define OMC_MODE_IDX    12'h00B
`define OMC_MODE_ADDR   (12'(`OMC_MODE_IDX * 4))

`define OMC_MB_SC       2'h0
`define OMC_MB_NARROW   2'h1
`define OMC_MB_PERIPH   2'h2
`define OMC_MB_WIDE     2'h3

`define OMC_BUS_CLOCK_STRETCH_EN_RST    1'b1
`define OMC_BUS_STOP_IN_WAIT_RST  1'b0
`define OMC_RSVD_RST    1'b0

`define OMC_DBG_REG_LO  16'hFF00
`define OMC_DBG_REG_HI  16'hFF06
`define OMC_DBG_ROM_LO  16'hFF20
`define OMC_TOP_HI      16'hFFFF
`define OMC_ADDR_STEP   16'h0001

`endif

// >>> omc_pkg.sv
// types shared by the operating-mode control block
package omc_pkg;

    typedef enum logic [1:0] {MD_SC, MD_NARROW, MD_PERIPH, MD_WIDE} omc_mode_t;

    typedef enum logic [1:0] {XF_IDLE, XF_ADDR, XF_DATA} omc_xfer_t;

    typedef struct packed {
        logic special_mode_n;
        logic mode_select_hi;
        logic mode_select_lo;
        logic bus_clock_stretch_en;
        logic internal_visibility;
        logic bus_stop_in_wait;
        logic rsvd;
        logic port_e_emulate;
    } omc_mode_reg_t;

    typedef struct packed {
        logic single_chip;
        logic expanded_narrow;
        logic expanded_wide;
        logic peripheral;
        logic special;
        logic cpu_hold;
        logic visibility;
        logic clock_stretch;
        logic port_e_mapped;
        logic bus_stop_in_wait;
    } omc_cfg_t;

    typedef struct packed {
        logic dbg_rom_sel;
        logic dbg_regs_sel;
        logic user_top_sel;
    } omc_map_t;

    typedef struct packed {
        logic [7:0] pa_out;
        logic       pa_oe;
        logic [7:0] pb_out;
        logic       pb_oe;
    } omc_pins_t;

    typedef struct packed {
        logic          captured;
        logic          wrote;
        omc_mode_reg_t mreg;
        logic          dbg_en;
        logic          dbg_act;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
        omc_xfer_t     xst;
        logic          xnarrow;
        logic          second;
        logic          xdone;
        logic [15:0]   xaddr;
        logic [15:0]   xdata;
        omc_cfg_t      cfg;
        omc_map_t      map;
        omc_pins_t     pins;
        logic          shutdown;
    } omc_state_t;

endpackage

// >>> omc_strap_sync.sv
// two-flop synchroniser for the mode strap pins
`timescale 1ns/1ps
module omc_strap_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] din,
    output wire logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } omc_sync_t;

    omc_sync_t st_ff;
    omc_sync_t nxt_st;

    // no reset: straps must flow through while reset is held
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.meta = din;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    assign dout = st_ff.sync;
endmodule

// >>> omc_top.sv
// operating-mode selection, mode register and debug window control
//
// Operation
// - straps latched into mode bits at reset release
// - strap table picks mode; peripheral forced special
// - single-chip modes drive no external bus
// - wide modes: 16-bit muxed bus on ports
// - narrow: port A data, high byte first
// - narrow second byte uses address plus one
// - peripheral mode holds processor, external master
// - peripheral mode entered or left only by reset
// - special single-chip: debug enabled and active
// - elsewhere debug needs enabling before activation
// - enabled debug activates on command or instruction
// - active debug maps firmware ROM and registers
// - active debug hides user top window
// - mode register unmapped in peripheral mode
// - mode register reset values follow latched mode
// - special flag writable only in special, not first
// - mode bits: normal once, special except first
// - writes selecting peripheral mode refused
// - clock stretch held set in expanded modes
// - visibility shows internal bus, never single-chip
// - port E emulation unmaps port E registers in expanded modes
// - bus stop in wait shuts bus when idle
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "omc_params.svh"
module omc_top (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`OMC_APB_AW-1:0]  paddr,
    input  wire logic [31:0]             pwdata,
    output wire logic [31:0]             prdata,
    output wire logic                    pready,
    output wire logic                    pslverr,
    input  wire logic                    background_pin,
    input  wire logic                    mode_select_hi,
    input  wire logic                    mode_select_lo,
    input  wire logic                    dbg_enable_cmd,
    input  wire logic                    dbg_serial_cmd,
    input  wire logic                    enter_debug_instruction,
    input  wire logic                    dbg_exit,
    input  wire logic [15:0]             cpu_addr,
    input  wire logic                    cpu_access,
    input  wire logic                    xfer_req,
    input  wire logic [15:0]             xfer_addr,
    input  wire logic [15:0]             xfer_data,
    input  wire logic                    wait_mode,
    output wire omc_pkg::omc_cfg_t       cfg,
    output wire omc_pkg::omc_map_t       mem_map,
    output wire omc_pkg::omc_pins_t      port_pins,
    output wire logic                    dbg_enabled,
    output wire logic                    dbg_active,
    output wire logic                    xfer_ack,
    output wire logic                    ext_bus_shutdown
);
    omc_pkg::omc_state_t    st_ff;
    omc_pkg::omc_state_t    nxt_st;
    logic [2:0]             strap_sync;
    logic                   apb_acc;
    logic                   reg_hit;
    logic                   wr_commit;
    logic                   bad_sel;
    logic                   xfer_go;
    logic                   expanded;
    omc_pkg::omc_mode_reg_t wd;
    omc_pkg::omc_mode_t     md;

    function automatic omc_pkg::omc_mode_t mode_of(input logic hi, input logic lo);
        logic [1:0] mb;
        mb = {hi, lo};
        unique case (mb)
            `OMC_MB_SC:     mode_of = omc_pkg::MD_SC;
            `OMC_MB_NARROW: mode_of = omc_pkg::MD_NARROW;
            `OMC_MB_PERIPH: mode_of = omc_pkg::MD_PERIPH;
            `OMC_MB_WIDE:   mode_of = omc_pkg::MD_WIDE;
        endcase
    endfunction

    function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction

    omc_strap_sync #(
        .W (3)
    ) u_strap (
        .clk  (clk),
        .din  ({background_pin, mode_select_hi, mode_select_lo}),
        .dout (strap_sync)
    );

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.xdone = 1'b0;
        nxt_st.pready  = 1'b0;
        nxt_st.pslverr = 1'b0;
        nxt_st.prdata  = '0;
        apb_acc   = psel & penable;
        reg_hit   = (paddr == `OMC_MODE_ADDR) & ~st_ff.cfg.peripheral;
        wd        = omc_pkg::omc_mode_reg_t'(pwdata[7:0]);
        bad_sel   = ({wd.mode_select_hi, wd.mode_select_lo} == `OMC_MB_PERIPH);
        wr_commit = apb_acc & st_ff.pready & pwrite & reg_hit;
        xfer_go   = 1'b0;

        if (!st_ff.captured) begin
            // first edge after release takes the synchronised straps
            nxt_st.captured            = 1'b1;
            nxt_st.mreg.special_mode_n = strap_sync[2];
            nxt_st.mreg.mode_select_hi = strap_sync[1];
            nxt_st.mreg.mode_select_lo = strap_sync[0];
            if (strap_sync[1:0] == `OMC_MB_PERIPH) begin
                nxt_st.mreg.special_mode_n = 1'b0;
            end
            nxt_st.mreg.bus_clock_stretch_en = `OMC_BUS_CLOCK_STRETCH_EN_RST;
            nxt_st.mreg.internal_visibility  = ~nxt_st.mreg.special_mode_n;
            nxt_st.mreg.port_e_emulate       = ~nxt_st.mreg.special_mode_n;
            nxt_st.mreg.bus_stop_in_wait     = `OMC_BUS_STOP_IN_WAIT_RST;
            nxt_st.mreg.rsvd                 = `OMC_RSVD_RST;
            nxt_st.dbg_en  = ~nxt_st.mreg.special_mode_n & (strap_sync[1:0] == `OMC_MB_SC);
            nxt_st.dbg_act = nxt_st.dbg_en;
        end else begin
            // one wait state: pready rises in the second access cycle
            if (apb_acc && !st_ff.pready) begin
                nxt_st.pready  = 1'b1;
                nxt_st.pslverr = ~reg_hit;
                nxt_st.prdata  = reg_hit ? {24'h000000, st_ff.mreg} : 32'h00000000;
            end
            if (wr_commit) begin
                nxt_st.wrote = 1'b1;
                if (!st_ff.mreg.special_mode_n) begin
                    nxt_st.mreg.bus_clock_stretch_en = wd.bus_clock_stretch_en;
                    if (st_ff.wrote) begin
                        if (!bad_sel) begin
                            nxt_st.mreg.special_mode_n = wd.special_mode_n;
                            nxt_st.mreg.mode_select_hi = wd.mode_select_hi;
                            nxt_st.mreg.mode_select_lo = wd.mode_select_lo;
                        end
                        nxt_st.mreg.internal_visibility = wd.internal_visibility;
                        nxt_st.mreg.port_e_emulate      = wd.port_e_emulate;
                    end
                end else begin
                    // normal mode: one shot at the once-only bits
                    nxt_st.mreg.bus_stop_in_wait = wd.bus_stop_in_wait;
                    if (!st_ff.wrote) begin
                        if (!bad_sel) begin
                            nxt_st.mreg.mode_select_hi = wd.mode_select_hi;
                            nxt_st.mreg.mode_select_lo = wd.mode_select_lo;
                        end
                        nxt_st.mreg.bus_clock_stretch_en = wd.bus_clock_stretch_en;
                        nxt_st.mreg.internal_visibility  = wd.internal_visibility;
                        nxt_st.mreg.port_e_emulate       = wd.port_e_emulate;
                    end
                end
            end

            if (dbg_enable_cmd) begin
                nxt_st.dbg_en = 1'b1;
            end
            if (dbg_exit) begin
                nxt_st.dbg_act = 1'b0;
            end
            // a command in the exit cycle wins so it is never lost
            if (st_ff.dbg_en && (dbg_serial_cmd || enter_debug_instruction)) begin
                nxt_st.dbg_act = 1'b1;
            end

            // ack cycle blocks a retake of a request still held high
            xfer_go = (st_ff.xst == omc_pkg::XF_IDLE) & xfer_req & ~st_ff.xdone & ~st_ff.shutdown
                      & (st_ff.cfg.expanded_narrow | st_ff.cfg.expanded_wide);
            unique case (st_ff.xst)
                omc_pkg::XF_IDLE: begin
                    if (xfer_go) begin
                        nxt_st.xst     = omc_pkg::XF_ADDR;
                        nxt_st.xaddr   = xfer_addr;
                        nxt_st.xdata   = xfer_data;
                        nxt_st.second  = 1'b0;
                        nxt_st.xnarrow = st_ff.cfg.expanded_narrow;
                    end
                end
                omc_pkg::XF_ADDR: begin
                    nxt_st.xst = omc_pkg::XF_DATA;
                end
                omc_pkg::XF_DATA: begin
                    if (st_ff.xnarrow && !st_ff.second) begin
                        nxt_st.second = 1'b1;
                        nxt_st.xaddr  = st_ff.xaddr + `OMC_ADDR_STEP;
                        nxt_st.xst    = omc_pkg::XF_ADDR;
                    end else begin
                        nxt_st.xst   = omc_pkg::XF_IDLE;
                        nxt_st.xdone = 1'b1;
                    end
                end
                default: begin
                    nxt_st.xst = omc_pkg::XF_IDLE;
                end
            endcase
        end

        // software may not leave stretch off while a bus is multiplexed
        md       = mode_of(nxt_st.mreg.mode_select_hi, nxt_st.mreg.mode_select_lo);
        expanded = nxt_st.captured & ((md == omc_pkg::MD_NARROW) | (md == omc_pkg::MD_WIDE));
        if (expanded) begin
            nxt_st.mreg.bus_clock_stretch_en = 1'b1;
        end

        nxt_st.cfg                  = '0;
        if (nxt_st.captured) begin
            nxt_st.cfg.single_chip      = (md == omc_pkg::MD_SC);
            nxt_st.cfg.expanded_narrow  = (md == omc_pkg::MD_NARROW);
            nxt_st.cfg.expanded_wide    = (md == omc_pkg::MD_WIDE);
            nxt_st.cfg.peripheral       = (md == omc_pkg::MD_PERIPH);
            nxt_st.cfg.special          = ~nxt_st.mreg.special_mode_n;
            nxt_st.cfg.cpu_hold         = (md == omc_pkg::MD_PERIPH);
            nxt_st.cfg.visibility       = nxt_st.mreg.internal_visibility & expanded;
            nxt_st.cfg.clock_stretch    = nxt_st.mreg.bus_clock_stretch_en;
            nxt_st.cfg.port_e_mapped    = ~(nxt_st.mreg.port_e_emulate & expanded)
                                          & (md != omc_pkg::MD_PERIPH);
            nxt_st.cfg.bus_stop_in_wait = nxt_st.mreg.bus_stop_in_wait;
        end

        // shut down only once the sequencer has drained
        nxt_st.shutdown = wait_mode & nxt_st.mreg.bus_stop_in_wait & expanded
                          & (nxt_st.xst == omc_pkg::XF_IDLE);

        nxt_st.map.dbg_rom_sel  = nxt_st.dbg_act & in_win(cpu_addr, `OMC_DBG_ROM_LO, `OMC_TOP_HI);
        nxt_st.map.dbg_regs_sel = nxt_st.dbg_act & in_win(cpu_addr, `OMC_DBG_REG_LO, `OMC_DBG_REG_HI);
        nxt_st.map.user_top_sel = ~nxt_st.dbg_act & in_win(cpu_addr, `OMC_DBG_REG_LO, `OMC_TOP_HI);

        nxt_st.pins = '0;
        unique case (nxt_st.xst)
            omc_pkg::XF_ADDR: begin
                nxt_st.pins.pa_out = nxt_st.xaddr[15:8];
                nxt_st.pins.pb_out = nxt_st.xaddr[7:0];
                nxt_st.pins.pa_oe  = 1'b1;
                nxt_st.pins.pb_oe  = 1'b1;
            end
            omc_pkg::XF_DATA: begin
                if (nxt_st.xnarrow) begin
                    nxt_st.pins.pa_out = nxt_st.second ? nxt_st.xdata[7:0] : nxt_st.xdata[15:8];
                    nxt_st.pins.pb_out = nxt_st.xaddr[7:0];
                end else begin
                    nxt_st.pins.pa_out = nxt_st.xdata[15:8];
                    nxt_st.pins.pb_out = nxt_st.xdata[7:0];
                end
                nxt_st.pins.pa_oe = 1'b1;
                nxt_st.pins.pb_oe = 1'b1;
            end
            omc_pkg::XF_IDLE: begin
                // visibility shows the address only; data lanes stay internal
                if (nxt_st.cfg.visibility && cpu_access) begin
                    nxt_st.pins.pa_out = cpu_addr[15:8];
                    nxt_st.pins.pb_out = cpu_addr[7:0];
                    nxt_st.pins.pa_oe  = 1'b1;
                    nxt_st.pins.pb_oe  = 1'b1;
                end
            end
            default: begin
                nxt_st.pins = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata           = st_ff.prdata;
    assign pready           = st_ff.pready;
    assign pslverr          = st_ff.pslverr;
    assign cfg              = st_ff.cfg;
    assign mem_map          = st_ff.map;
    assign port_pins        = st_ff.pins;
    assign dbg_enabled      = st_ff.dbg_en;
    assign dbg_active       = st_ff.dbg_act;
    assign xfer_ack         = st_ff.xdone;
    assign ext_bus_shutdown = st_ff.shutdown;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_ssc_dbg_live: assert property ($rose(st_ff.captured) && !st_ff.mreg.special_mode_n
        && st_ff.cfg.single_chip |-> st_ff.dbg_en && st_ff.dbg_act)
        else $error("debug not live after special single-chip reset");

    a_dbg_needs_en: assert property (!st_ff.dbg_en |-> !st_ff.dbg_act)
        else $error("debug active without enable");

    a_dbg_activate: assert property (st_ff.captured && st_ff.dbg_en && !dbg_exit
        && (dbg_serial_cmd || enter_debug_instruction) |=> st_ff.dbg_act)
        else $error("enabled debug failed to activate");

    a_periph_locked: assert property (st_ff.captured |=>
        st_ff.cfg.peripheral == $past(st_ff.cfg.peripheral))
        else $error("peripheral mode changed without reset");

    a_mode_unmapped: assert property (st_ff.cfg.peripheral && psel && penable && pready
        |-> pslverr && prdata == 32'h00000000)
        else $error("mode register visible in peripheral mode");

    a_narrow_incr: assert property ($rose(st_ff.second)
        |-> st_ff.xaddr == $past(st_ff.xaddr) + `OMC_ADDR_STEP)
        else $error("second narrow byte address not incremented");

    a_narrow_len: assert property (xfer_go && st_ff.cfg.expanded_narrow
        |-> ##5 xfer_ack)
        else $error("narrow transfer not two byte cycles");

    a_wide_len: assert property (xfer_go && st_ff.cfg.expanded_wide
        |-> ##3 xfer_ack)
        else $error("wide transfer not one cycle pair");

    a_sc_no_bus: assert property (st_ff.cfg.single_chip
        |-> !port_pins.pa_oe && !port_pins.pb_oe)
        else $error("single-chip mode drives ports");

    a_bus_clock_stretch_en_held: assert property (st_ff.cfg.expanded_narrow || st_ff.cfg.expanded_wide
        |-> st_ff.mreg.bus_clock_stretch_en)
        else $error("clock stretch clear in expanded mode");

    a_sel_refused: assert property (wr_commit && bad_sel
        |=> $stable({st_ff.mreg.special_mode_n, st_ff.mreg.mode_select_hi, st_ff.mreg.mode_select_lo}))
        else $error("refused mode selection took effect");

    a_top_hidden: assert property (st_ff.dbg_act && $past(cpu_addr) >= `OMC_DBG_REG_LO
        |-> !mem_map.user_top_sel)
        else $error("user top window mapped during debug");

    a_sc_no_vis: assert property (st_ff.cfg.single_chip |-> !st_ff.cfg.visibility)
        else $error("visibility in single-chip mode");

    c_narrow_xfer: cover property (xfer_go && st_ff.cfg.expanded_narrow ##5 xfer_ack);
    c_dbg_enter: cover property (!st_ff.dbg_act ##1 st_ff.dbg_act);
    c_periph_boot: cover property ($rose(st_ff.captured) && st_ff.cfg.peripheral);
    c_sw_to_normal: cover property (!st_ff.mreg.special_mode_n ##1 st_ff.mreg.special_mode_n);
endmodule

// >>> tb_top.sv
// self-checking bench for the operating-mode control block
`timescale 1ns/1ps
`include "omc_params.svh"
module tb_top;
    logic               clk = 1'b0;
    logic               srst = 1'b1;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [2:0]         straps = 3'h0;
    logic [3:0]         dbg_p = 4'h0;
    logic [15:0]        cpu_addr = 16'h0;
    logic               cpu_access = 1'b0;
    logic               xfer_req = 1'b0;
    logic [15:0]        xfer_addr = 16'h0;
    logic [15:0]        xfer_data = 16'h0;
    logic               wait_mode = 1'b0;
    omc_pkg::omc_cfg_t  cfg;
    omc_pkg::omc_map_t  mem_map;
    omc_pkg::omc_pins_t port_pins;
    logic               dbg_enabled;
    logic               dbg_active;
    logic               xfer_ack;
    logic               ext_bus_shutdown;
    logic [31:0]        rdat;
    logic               rerr;
    logic [7:0]         e;
    logic               sc;
    logic               pe;
    int                 failures = 0;
    int                 tests_run = 0;
    int                 cyc = 0;
    int                 n;

    // processor internal accesses stay low except in the visibility test, outside any logged transfer
    omc_top u_omc_top (
        .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .background_pin(straps[2]), .mode_select_hi(straps[1]), .mode_select_lo(straps[0]),
        .dbg_enable_cmd(dbg_p[0]), .dbg_serial_cmd(dbg_p[1]), .enter_debug_instruction(dbg_p[2]),
        .dbg_exit(dbg_p[3]), .cpu_addr, .cpu_access, .xfer_req, .xfer_addr, .xfer_data,
        .wait_mode, .cfg, .mem_map, .port_pins, .dbg_enabled, .dbg_active, .xfer_ack, .ext_bus_shutdown
    );

    omc_ext_bus_model u_omc_ext_bus_model (.clk, .port_pins);

    always #5 clk = ~clk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task give_verdict();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            failures++;
            give_verdict();
        end
    end

    task do_reset(input logic [2:0] s);
        @(posedge clk);
        straps <= s;
        srst <= 1'b1;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wchk(input logic [7:0] d, input logic [7:0] exp);
        acc(1'b1, `OMC_MODE_ADDR, d);
        acc(1'b0, `OMC_MODE_ADDR, 8'h00);
        check("mode_reg", rdat, {24'h0, exp});
    endtask

    task pulse(input int b, input logic exp);
        @(posedge clk);
        dbg_p[b] <= 1'b1;
        @(posedge clk);
        dbg_p[b] <= 1'b0;
        repeat (2) @(posedge clk);
        check("dbg_active", dbg_active, exp);
    endtask

    task mapchk(input logic [15:0] a, input logic [2:0] exp);
        @(posedge clk);
        cpu_addr <= a;
        repeat (3) @(posedge clk);
        check("mem_map", mem_map, exp);
    endtask

    // exp_log packs up to four {port a, port b} phases, first phase in the top bits
    task xfer(input logic [15:0] a, input logic [15:0] d, input int exp_n, input int cnt, input logic [63:0] exp_log);
        u_omc_ext_bus_model.log.delete();
        @(posedge clk);
        xfer_req <= 1'b1;
        xfer_addr <= a;
        xfer_data <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (xfer_ack !== 1'b1 && n < 12);
        xfer_req <= 1'b0;
        check("xfer_cycles", n, exp_n);
        check("xfer_phases", u_omc_ext_bus_model.log.size(), cnt);
        for (int k = 0; k < cnt && k < u_omc_ext_bus_model.log.size(); k++) begin
            check("xfer_phase", u_omc_ext_bus_model.log[k], exp_log[63-16*k -: 16]);
        end
    endtask

    initial begin
        for (int i = 0; i < 8; i++) begin
            do_reset(i[2:0]);
            sc = (i[1:0] == 2'b00);
            pe = (i[1:0] == 2'b10);
            e = i[2] ? {i[2:0], 5'h10} : {i[2:0], 5'h19};
            acc(1'b0, `OMC_MODE_ADDR, 8'h00);
            check("mode_rst", rdat, pe ? 32'h0 : {24'h0, e});
            check("mode_err", rerr, pe);
            check("cpu_hold", cfg.cpu_hold, pe);
            check("single_chip", cfg.single_chip, sc);
            check("visibility", cfg.visibility, !i[2] && i[0]);
            check("port_e_mapped", cfg.port_e_mapped, !pe && !(!i[2] && i[0]));
            check("dbg_rst", dbg_active, !i[2] && sc);
            if (sc) begin
                xfer(16'h5A5A, 16'h0F0F, 12, 0, 64'h0);
            end
        end
        wchk(8'hE0, 8'hF0);
        check("stretch", cfg.clock_stretch, 1'b1);
        wchk(8'hB0, 8'hF0);
        acc(1'b0, 12'h030, 8'h00);
        check("unmapped_data", rdat, 32'h0);
        check("unmapped_err", rerr, 1'b1);
        check("wide", cfg.expanded_wide, 1'b1);
        xfer(16'h12FF, 16'hABCD, 4, 2, 64'h12FF_ABCD_0000_0000);
        mapchk(16'hFF30, 3'b001);
        // debug stimulus only outside peripheral mode
        pulse(2, 1'b0);
        pulse(0, 1'b0);
        check("dbg_enabled", dbg_enabled, 1'b1);
        pulse(1, 1'b1);
        mapchk(16'hFF20, 3'b100);
        mapchk(16'hFF06, 3'b010);
        mapchk(16'hFF1F, 3'b000);
        pulse(3, 1'b0);
        pulse(2, 1'b1);
        pulse(3, 1'b0);
        wchk(8'hF4, 8'hF4);
        check("bus_stop", cfg.bus_stop_in_wait, 1'b1);
        @(posedge clk);
        wait_mode <= 1'b1;
        repeat (4) @(posedge clk);
        check("shutdown", ext_bus_shutdown, 1'b1);
        xfer(16'h0100, 16'h0001, 12, 0, 64'h0);
        wait_mode <= 1'b0;
        do_reset(3'b001);
        xfer(16'h12FF, 16'hABCD, 6, 4, 64'h12FF_ABFF_1300_CD00);
        @(posedge clk);
        cpu_access <= 1'b1;
        cpu_addr <= 16'h2468;
        repeat (2) @(posedge clk);
        check("vis_pins", port_pins, {8'h24, 1'b1, 8'h68, 1'b1});
        cpu_access <= 1'b0;
        wchk(8'h79, 8'h39);
        wchk(8'h79, 8'h79);
        wchk(8'h59, 8'h79);
        wchk(8'hF9, 8'hF9);
        check("special", cfg.special, 1'b0);
        give_verdict();
    end
endmodule
